// [hlt_pkg.sv]
package hlt_pkg;

    // ****************************************
    // bus map
    // ****************************************
    localparam int ADR_W = 5;
    localparam int DAT_W = 32;
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_PERIOD = 5'h04;
    localparam logic [4:0] OFF_COUNT = 5'h08;
    localparam logic [4:0] OFF_PWC = 5'h0C;
    localparam logic [4:0] OFF_STATUS = 5'h10;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ON_BIT = 7;
    localparam int CTRL_SYNC_BIT = 8;
    localparam int STAT_PWM_BIT = 0;
    localparam int STAT_ARM_BIT = 1;
    localparam int STAT_RUN_BIT = 2;
    localparam int STAT_ERS_BIT = 3;
    localparam logic [7:0] PERIOD_RST = 8'hFF;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] PWC_RST = 8'h00;
    localparam logic [4:0] MODE_RST = 5'h00;

    // ****************************************
    // timing
    // ****************************************
    localparam logic [1:0] RESTART_DLY = 2'h2;

    typedef enum logic [3:0] {
        CLS_GATE, CLS_EDGE_LIMIT, CLS_LEVEL_LIMIT, CLS_SW_ONESHOT,
        CLS_EDGE_ONESHOT, CLS_EDGE_LIMIT_ONESHOT, CLS_LVL_EDGE_ONESHOT,
        CLS_MONO, CLS_LVL_ONESHOT, CLS_RESERVED
    } hlt_class_t;

    function automatic hlt_class_t hltModeClass(input logic [4:0] m);
        hlt_class_t c;
        c = CLS_RESERVED;
        case (m)
            5'h00, 5'h01, 5'h02: c = CLS_GATE;
            5'h03, 5'h04, 5'h05: c = CLS_EDGE_LIMIT;
            5'h06, 5'h07: c = CLS_LEVEL_LIMIT;
            5'h08: c = CLS_SW_ONESHOT;
            5'h09, 5'h0A, 5'h0B: c = CLS_EDGE_ONESHOT;
            5'h0C, 5'h0D: c = CLS_EDGE_LIMIT_ONESHOT;
            5'h0E, 5'h0F: c = CLS_LVL_EDGE_ONESHOT;
            5'h11, 5'h12, 5'h13: c = CLS_MONO;
            5'h16, 5'h17: c = CLS_LVL_ONESHOT;
            default: c = CLS_RESERVED;
        endcase
        return c;
    endfunction

endpackage

// [hlt_ers_if.sv]
`timescale 1ns/100ps
interface hlt_ers_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

// [hlt_ers_sync.sv]
`timescale 1ns/100ps
module hlt_ers_sync (
    input wire logic clock,
    input wire logic rstn,
    input wire logic pinIn,
    hlt_ers_if.src ers
);
    logic stage1_reg;
    logic stage2_reg;
    logic prev_reg;
    logic [2:0] warm_reg;

    // ****************************************
    // two-flop synchroniser, then edge detect
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prev_reg <= 1'b0;
            warm_reg <= 3'h0;
        end else begin
            prev_reg <= stage2_reg;
            warm_reg <= {warm_reg[1:0], 1'b1};
        end
    end

    assign ers.level = stage2_reg;
    // no false edge while the pipe still holds reset values
    assign ers.rise = stage2_reg & ~prev_reg & warm_reg[2];
    assign ers.fall = ~stage2_reg & prev_reg & warm_reg[2];
endmodule // hlt_ers_sync

// [hlt_timer.sv]
`timescale 1ns/100ps
// Notes on behaviour
// RULE1: edge limit modes reset count on any, rising or falling external edge
// RULE2: early edge reset restarts the pulse two clocks later
// RULE3: level limit modes reset count while signal is low or high
// RULE4: level limit modes ignore the external signal while enable is clear
// RULE5: level reset acts two clocks after assertion, resumes two after release
// RULE6: level limit pulse rises on start, falls on compare, held during reset
// RULE7: software one-shot clears enable and count at period match
// RULE8: software one-shot pulse starts with enable, pausing stretches it
// RULE9: edge one-shot starts on selected edge after enable, clears on match
// RULE10: halted edge one-shot needs a new edge after re-enable
// RULE11: limit one-shot: first edge starts, later edges reset, resume in two
// RULE12: limit one-shot match clears enable; edges ignored while disabled
// RULE13: start and reset edges raise the pulse; compare match drops it
// RULE14: level-reset one-shot holds at reset level, starts on active edge
// RULE15: level-reset one-shot match clears enable; restart needs fresh edge
// RULE16: level-reset one-shot pulse not raised again at period match
// RULE17: monostable starts on selected edge after enable, stops at match
// RULE18: monostable ignores further edges while counting
// RULE19: level one-shot holds at reset level, runs when enabled and released
// RULE20: level one-shot match clears enable; stays reset until both conditions
// RULE21: level one-shot pulse rises on whichever event starts the timer
// RULE22: with sync selected the timer freezes in sleep, else keeps running
// RULE23: one-shot: clock after count equals period clears enable, count zero
// RULE24: monostable: clock after match stops count at zero, enable kept
// RULE25: periodic modes wrap to zero the clock after period match
// RULE26: unassigned mode codes hold count at zero, pulse low
module hlt_timer (
    input wire logic clock,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [hlt_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [hlt_pkg::DAT_W-1:0] wb_dat_i,
    output logic [hlt_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic extResetTrigger,
    input wire logic sleepMode,
    output logic pwmDrive,
    output logic [7:0] countValue
);
    import hlt_pkg::*;

    hlt_ers_if ers ();

    logic ack_reg;
    logic [DAT_W-1:0] rdData_reg;
    logic [DAT_W-1:0] rdData_next;
    logic on_reg;
    logic onPrev_reg;
    logic [4:0] mode_reg;
    logic clockSyncSelect_reg;
    logic [7:0] periodValue_reg;
    logic [7:0] countValue_reg;
    logic [7:0] pulseWidthCompare_reg;
    logic pwm_reg;
    logic arm_reg;
    logic [1:0] dly_reg;
    logic [2:0] lvlPipe_reg;

    logic wrEn;
    logic wrCtrl;
    logic wrCount;
    logic frozen;
    hlt_class_t cls;
    logic hit;
    logic atRstLvl;
    logic periodMatch;
    logic pwMatch;
    logic onRise;
    logic lvlHeld;
    logic lvlRel;
    logic cntClear;
    logic cntRun;
    logic startEv;
    logic onClrHw;
    logic armSet;
    logic armClr;
    logic dlyLoad;

    // ****************************************
    // external signal input
    // ****************************************
    hlt_ers_sync u_sync (
        .clock(clock),
        .rstn(rstn),
        .pinIn(extResetTrigger),
        .ers(ers)
    );

    function automatic logic edgeHit(input logic [4:0] m,
                                     input logic r, input logic f);
        logic h;
        h = 1'b0;
        case (m)
            5'h03, 5'h0B, 5'h13: h = r | f;
            5'h04, 5'h09, 5'h0C, 5'h0E, 5'h11: h = r;
            5'h05, 5'h0A, 5'h0D, 5'h0F, 5'h12: h = f;
            default: h = 1'b0;
        endcase
        return h;
    endfunction

    // ****************************************
    // wishbone slave
    // ****************************************
    assign wrEn = ack_reg & wb_cyc_i & wb_stb_i & wb_we_i;
    assign wrCtrl = wrEn & (wb_adr_i == OFF_CTRL);
    assign wrCount = wrEn & (wb_adr_i == OFF_COUNT) & wb_sel_i[0];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
        end
    end

    always_comb begin
        rdData_next = '0;
        if (wb_adr_i == OFF_CTRL) begin
            rdData_next[CTRL_MODE_LSB +: 5] = mode_reg;
            rdData_next[CTRL_ON_BIT] = on_reg;
            rdData_next[CTRL_SYNC_BIT] = clockSyncSelect_reg;
        end else if (wb_adr_i == OFF_PERIOD) begin
            rdData_next[7:0] = periodValue_reg;
        end else if (wb_adr_i == OFF_COUNT) begin
            rdData_next[7:0] = countValue_reg;
        end else if (wb_adr_i == OFF_PWC) begin
            rdData_next[7:0] = pulseWidthCompare_reg;
        end else if (wb_adr_i == OFF_STATUS) begin
            rdData_next[STAT_PWM_BIT] = pwm_reg;
            rdData_next[STAT_ARM_BIT] = arm_reg;
            rdData_next[STAT_RUN_BIT] = cntRun;
            rdData_next[STAT_ERS_BIT] = ers.level;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdData_reg <= '0;
        end else if (wb_cyc_i & wb_stb_i & ~ack_reg) begin
            rdData_reg <= rdData_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdData_reg;

    // ****************************************
    // software registers
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mode_reg <= MODE_RST;
            clockSyncSelect_reg <= 1'b0;
        end else if (wrCtrl) begin
            if (wb_sel_i[0]) begin
                mode_reg <= wb_dat_i[CTRL_MODE_LSB +: 5];
            end
            if (wb_sel_i[1]) begin
                clockSyncSelect_reg <= wb_dat_i[CTRL_SYNC_BIT];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            periodValue_reg <= PERIOD_RST;
            pulseWidthCompare_reg <= PWC_RST;
        end else if (wrEn & wb_sel_i[0]) begin
            if (wb_adr_i == OFF_PERIOD) begin
                periodValue_reg <= wb_dat_i[7:0];
            end else if (wb_adr_i == OFF_PWC) begin
                pulseWidthCompare_reg <= wb_dat_i[7:0];
            end
        end
    end

    // software write wins over a hardware clear in the same cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            on_reg <= 1'b0;
        end else if (wrCtrl & wb_sel_i[0]) begin
            on_reg <= wb_dat_i[CTRL_ON_BIT];
        end else if (onClrHw & ~frozen) begin
            on_reg <= 1'b0; // [RULE7] [RULE23]
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            onPrev_reg <= 1'b0;
        end else begin
            onPrev_reg <= on_reg;
        end
    end

    // ****************************************
    // mode decode
    // ****************************************
    assign frozen = clockSyncSelect_reg & sleepMode; // [RULE22]
    assign cls = hltModeClass(mode_reg);
    assign hit = edgeHit(mode_reg, ers.rise, ers.fall);
    assign atRstLvl = (ers.level == mode_reg[0]); // [RULE3]
    assign periodMatch = (countValue_reg == periodValue_reg);
    assign pwMatch = (countValue_reg == pulseWidthCompare_reg);
    assign onRise = on_reg & ~onPrev_reg;
    assign lvlHeld = lvlPipe_reg[1];
    assign lvlRel = lvlPipe_reg[2] & ~lvlPipe_reg[1];

    // level reset seen two clocks late, only while enabled
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lvlPipe_reg <= 3'h0;
        end else if (!frozen) begin
            lvlPipe_reg <= {lvlPipe_reg[1:0],
                            on_reg & atRstLvl &
                            (cls == CLS_LEVEL_LIMIT)}; // [RULE4] [RULE5]
        end
    end

    always_comb begin
        cntClear = 1'b0;
        cntRun = 1'b0;
        startEv = 1'b0;
        onClrHw = 1'b0;
        armSet = 1'b0;
        armClr = 1'b0;
        dlyLoad = 1'b0;
        case (cls)
            CLS_GATE: begin
                cntRun = on_reg & ((mode_reg == 5'h00) |
                         ((mode_reg == 5'h01) & ~ers.level) |
                         ((mode_reg == 5'h02) & ers.level));
                startEv = onRise | (cntRun & periodMatch);
            end
            CLS_EDGE_LIMIT: begin
                if (on_reg & hit) begin
                    cntClear = 1'b1; // [RULE1]
                    dlyLoad = 1'b1;
                end else begin
                    cntRun = on_reg & (dly_reg == 2'h0);
                end
                startEv = (dly_reg == 2'h1) | onRise |
                          (cntRun & periodMatch); // [RULE2]
            end
            CLS_LEVEL_LIMIT: begin
                if (on_reg & lvlHeld) begin
                    cntClear = 1'b1; // [RULE5]
                end else begin
                    cntRun = on_reg;
                end
                startEv = (on_reg & lvlRel) | onRise |
                          (cntRun & periodMatch); // [RULE6]
            end
            CLS_SW_ONESHOT: begin
                cntRun = on_reg;
                startEv = onRise & (countValue_reg == COUNT_RST); // [RULE8]
                onClrHw = cntRun & periodMatch; // [RULE7]
            end
            CLS_EDGE_ONESHOT: begin
                if (!on_reg) begin
                    armClr = 1'b1; // [RULE10]
                end else if (hit & ~arm_reg) begin
                    armSet = 1'b1; // [RULE9]
                    startEv = 1'b1;
                end
                cntRun = on_reg & arm_reg;
                onClrHw = cntRun & periodMatch; // [RULE9]
            end
            CLS_EDGE_LIMIT_ONESHOT: begin
                if (!on_reg) begin
                    armClr = 1'b1; // [RULE12]
                end else if (hit & ~arm_reg) begin
                    armSet = 1'b1; // [RULE11]
                    startEv = 1'b1; // [RULE13]
                end else if (hit) begin
                    cntClear = 1'b1; // [RULE11]
                    dlyLoad = 1'b1;
                end
                cntRun = on_reg & arm_reg & ~hit & (dly_reg == 2'h0);
                if (on_reg & arm_reg & (dly_reg == 2'h1)) begin
                    startEv = 1'b1; // [RULE13]
                end
                onClrHw = cntRun & periodMatch; // [RULE12]
            end
            CLS_LVL_EDGE_ONESHOT: begin
                if (atRstLvl) begin
                    cntClear = 1'b1; // [RULE14]
                    armClr = 1'b1;
                end else if (!on_reg) begin
                    armClr = 1'b1; // [RULE15]
                end else if (hit & ~arm_reg) begin
                    armSet = 1'b1; // [RULE14]
                    startEv = 1'b1; // [RULE16]
                end
                cntRun = on_reg & arm_reg & ~atRstLvl;
                onClrHw = cntRun & periodMatch; // [RULE15]
            end
            CLS_MONO: begin
                if (!on_reg) begin
                    armClr = 1'b1;
                end else if (hit & ~arm_reg) begin
                    armSet = 1'b1; // [RULE17]
                    startEv = 1'b1; // [RULE18]
                end
                cntRun = on_reg & arm_reg;
            end
            CLS_LVL_ONESHOT: begin
                if (on_reg & ~atRstLvl) begin
                    cntRun = 1'b1; // [RULE19]
                    armSet = 1'b1;
                    startEv = ~arm_reg; // [RULE21]
                end else begin
                    cntClear = 1'b1; // [RULE20]
                    armClr = 1'b1;
                end
                onClrHw = cntRun & periodMatch; // [RULE20]
            end
            default: begin
                cntClear = 1'b1; // [RULE26]
            end
        endcase
        // a period match ends every armed cycle
        if (cntRun & periodMatch & (cls != CLS_GATE) &
            (cls != CLS_EDGE_LIMIT) & (cls != CLS_LEVEL_LIMIT)) begin
            armClr = 1'b1; // [RULE24]
            armSet = 1'b0;
        end
    end

    // ****************************************
    // counter, arm flag, restart delay, pulse
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            countValue_reg <= COUNT_RST;
        end else if (frozen) begin
            countValue_reg <= countValue_reg; // [RULE22]
        end else if (wrCount) begin
            countValue_reg <= wb_dat_i[7:0];
        end else if (cntClear) begin
            countValue_reg <= COUNT_RST;
        end else if (cntRun & periodMatch) begin
            countValue_reg <= COUNT_RST; // [RULE25] [RULE23] [RULE24]
        end else if (cntRun) begin
            countValue_reg <= countValue_reg + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            arm_reg <= 1'b0;
        end else if (!frozen) begin
            if (armSet) begin
                arm_reg <= 1'b1;
            end else if (armClr) begin
                arm_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dly_reg <= 2'h0;
        end else if (!frozen) begin
            if (dlyLoad) begin
                dly_reg <= RESTART_DLY; // [RULE2] [RULE11]
            end else if (dly_reg != 2'h0) begin
                dly_reg <= dly_reg - 2'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pwm_reg <= 1'b0;
        end else if (frozen) begin
            pwm_reg <= pwm_reg;
        end else if (cls == CLS_RESERVED) begin
            pwm_reg <= 1'b0; // [RULE26]
        end else if (startEv) begin
            pwm_reg <= 1'b1;
        end else if (cntRun & pwMatch) begin
            pwm_reg <= 1'b0; // [RULE6] [RULE13] [RULE16]
        end
    end

    assign pwmDrive = pwm_reg;
    assign countValue = countValue_reg;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    logic wrAny;
    assign wrAny = wrEn;

    property p_oneshot_end;
        (cls == CLS_SW_ONESHOT) && cntRun && periodMatch && !wrAny
        && !frozen |=> !on_reg && (countValue_reg == COUNT_RST);
    endproperty
    a_oneshot_end: assert property (p_oneshot_end) // [RULE7]
        else $error("one-shot match did not stop");

    property p_mono_keep_on;
        (cls == CLS_MONO) && cntRun && periodMatch && !wrAny && !frozen
        |=> on_reg && !arm_reg && (countValue_reg == COUNT_RST);
    endproperty
    a_mono_keep_on: assert property (p_mono_keep_on) // [RULE24]
        else $error("monostable match wrong");

    property p_gate_wrap;
        (cls == CLS_GATE) && cntRun && periodMatch && !wrAny && !frozen
        |=> (countValue_reg == COUNT_RST) and ((cntRun && !frozen && !wrAny
        && !periodMatch) |=> (countValue_reg == 8'h01));
    endproperty
    a_gate_wrap: assert property (p_gate_wrap) // [RULE25]
        else $error("periodic wrap missing");

    property p_edge_limit_reset;
        (cls == CLS_EDGE_LIMIT) && on_reg && hit && !wrAny && !frozen
        |=> (countValue_reg == COUNT_RST) && (dly_reg == RESTART_DLY);
    endproperty
    a_edge_limit_reset: assert property (p_edge_limit_reset) // [RULE1]
        else $error("edge limit reset missing");

    property p_restart_pulse;
        (cls == CLS_EDGE_LIMIT) && on_reg && (dly_reg == 2'h1) && !frozen
        && !wrAny |=> pwm_reg
        && (dly_reg == ($past(hit) ? RESTART_DLY : 2'h0));
    endproperty
    a_restart_pulse: assert property (p_restart_pulse) // [RULE2]
        else $error("pulse not restarted after delay");

    property p_level_delay;
        ((cls == CLS_LEVEL_LIMIT) && on_reg && atRstLvl && !frozen)[*2]
        ##1 !frozen |-> lvlHeld;
    endproperty
    a_level_delay: assert property (p_level_delay) // [RULE5]
        else $error("level reset not applied in two clocks");

    property p_level_off_ignored;
        (cls == CLS_LEVEL_LIMIT) && !on_reg && !frozen |=> !lvlPipe_reg[0];
    endproperty
    a_level_off_ignored: assert property (p_level_off_ignored) // [RULE4]
        else $error("signal not ignored while disabled");

    property p_pwm_held;
        (cls == CLS_LEVEL_LIMIT) && pwm_reg && lvlHeld && on_reg
        && !wrAny |=> pwm_reg;
    endproperty
    a_pwm_held: assert property (p_pwm_held) // [RULE6]
        else $error("pulse dropped during reset");

    property p_sleep_freeze;
        frozen && !wrAny |=> $stable(countValue_reg) && $stable(pwm_reg)
        && $stable(periodValue_reg);
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) // [RULE22]
        else $error("timer moved while frozen");

    property p_reserved_idle;
        (cls == CLS_RESERVED) && !wrAny && !frozen
        |=> (countValue_reg == COUNT_RST) && !pwm_reg;
    endproperty
    a_reserved_idle: assert property (p_reserved_idle) // [RULE26]
        else $error("reserved mode not idle");

    property p_mono_edges;
        (cls == CLS_MONO) && arm_reg && on_reg && !pwm_reg && !frozen
        && !wrAny |=> !pwm_reg;
    endproperty
    a_mono_edges: assert property (p_mono_edges) // [RULE18]
        else $error("edge retriggered monostable pulse");

    property p_wait_edge;
        (cls == CLS_EDGE_ONESHOT) && !arm_reg && !wrAny
        |=> $stable(countValue_reg);
    endproperty
    a_wait_edge: assert property (p_wait_edge) // [RULE10]
        else $error("counted without start edge");

    c_oneshot_done: cover property (onClrHw && !frozen);
    c_edge_restart: cover property (dlyLoad && pwm_reg);
    c_level_release: cover property (lvlRel && on_reg);
    c_mono_start: cover property ((cls == CLS_MONO) && armSet);
endmodule // hlt_timer

// [hlt_ers_src.sv]
`timescale 1ns/100ps
module hlt_ers_src (
    input wire logic clock,
    output logic pinOut
);
    initial pinOut = 1'b0;
    // one level change, launched just after an edge
    task automatic drive(input logic v);
        @(posedge clock);
        pinOut <= v;
    endtask
endmodule // hlt_ers_src

// [hlt_timer_test.sv]
`timescale 1ns/100ps
module hlt_timer_test;
    import hlt_pkg::*;
    logic clock, rstn, cyc, stb, we, sleepMode, pin, pwmDrive, ack;
    logic [4:0] adr;
    logic [31:0] dat, q, rd;
    logic [7:0] countValue, v;
    int errors = 0;
    int checks_done = 0;
    hlt_ers_src i_hlt_ers_src (.clock(clock), .pinOut(pin));
    hlt_timer i_hlt_timer (.clock(clock), .rstn(rstn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
        .extResetTrigger(pin), .sleepMode(sleepMode),
        .pwmDrive(pwmDrive), .countValue(countValue));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic summarize;
        $display("errors=%0d checks=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic hang;
        errors++;
        $display("unexpected at %0t: wait ran out", $time);
        summarize();
    endtask
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) hang();
        q = rd;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clock);
    endtask
    task automatic waitCount(input logic [7:0] c);
        int n;
        n = 0;
        while (countValue !== c && n < 600) begin
            @(posedge clock);
            n++;
        end
        if (n >= 600) hang();
    endtask
    task automatic setup(input logic [7:0] per, input logic lvl);
        wb(1'b1, OFF_CTRL, 32'h0000_0000);
        wb(1'b1, OFF_COUNT, 32'h0000_0000);
        wb(1'b1, OFF_PERIOD, {24'h0, per});
        wb(1'b1, OFF_PWC, 32'h0000_0020);
        i_hlt_ers_src.drive(lvl);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic tSwOneShot;
        setup(8'h05, 1'b0);
        wb(1'b1, OFF_PWC, 32'h0000_0002);
        wb(1'b1, OFF_CTRL, 32'h0000_0088);
        @(posedge clock);
        chk(pwmDrive, 1'b1);
        waitCount(8'h05);
        chk(pwmDrive, 1'b0);
        repeat (3) @(posedge clock);
        chk(countValue, 8'h00);
        wb(1'b0, OFF_CTRL, 32'h0000_0000);
        chk(q, 32'h0000_0008);
    endtask
    task automatic tEdgeLimit(input logic [4:0] m);
        setup(8'hFF, m == 5'h05);
        wb(1'b1, OFF_CTRL, {24'h0, 3'b100, m});
        waitCount(8'h30);
        i_hlt_ers_src.drive(m != 5'h05);
        repeat (5) @(posedge clock);
        chk(countValue, 8'h00);
        repeat (3) @(posedge clock);
        chk(pwmDrive, 1'b1);
    endtask
    task automatic tLevelLimit(input logic [4:0] m);
        setup(8'hFF, ~m[0]);
        wb(1'b1, OFF_CTRL, {24'h0, 3'b100, m});
        waitCount(8'h10);
        i_hlt_ers_src.drive(m[0]);
        repeat (25) @(posedge clock);
        chk(countValue, 8'h00);
        i_hlt_ers_src.drive(~m[0]);
        repeat (10) @(posedge clock);
        chk(32'(countValue != 8'h00), 32'h1);
    endtask
    task automatic tMono;
        setup(8'h03, 1'b0);
        wb(1'b1, OFF_CTRL, 32'h0000_0091);
        i_hlt_ers_src.drive(1'b1);
        waitCount(8'h03);
        repeat (4) @(posedge clock);
        chk(countValue, 8'h00);
        wb(1'b0, OFF_CTRL, 32'h0000_0000);
        chk(q, 32'h0000_0091);
    endtask
    task automatic tReserved;
        setup(8'h03, 1'b0);
        wb(1'b1, OFF_CTRL, 32'h0000_0094);
        wb(1'b1, OFF_COUNT, 32'h0000_0042);
        repeat (10) @(posedge clock);
        chk(countValue, 8'h00);
        chk(pwmDrive, 1'b0);
    endtask
    task automatic tSleep;
        setup(8'hFF, 1'b0);
        wb(1'b1, OFF_CTRL, 32'h0000_0180);
        waitCount(8'h10);
        sleepMode <= 1'b1;
        repeat (2) @(posedge clock);
        v = countValue;
        repeat (10) @(posedge clock);
        chk(countValue, v);
        wb(1'b1, OFF_CTRL, 32'h0000_0080);
        repeat (4) @(posedge clock);
        chk(32'(countValue != v), 32'h1);
        sleepMode <= 1'b0;
    endtask
    task automatic tOneShots;
        setup(8'h04, 1'b0);
        wb(1'b1, OFF_CTRL, 32'h0000_0089);
        repeat (10) @(posedge clock);
        chk(countValue, 8'h00);
        i_hlt_ers_src.drive(1'b1);
        waitCount(8'h04);
        repeat (3) @(posedge clock);
        wb(1'b0, OFF_CTRL, 32'h0000_0000);
        chk(q, 32'h0000_0009);
        setup(8'h04, 1'b1);
        wb(1'b1, OFF_CTRL, 32'h0000_0096);
        waitCount(8'h04);
        repeat (3) @(posedge clock);
        chk(countValue, 8'h00);
        wb(1'b0, OFF_CTRL, 32'h0000_0000);
        chk(q, 32'h0000_0016);
    endtask
    initial begin
        rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; sleepMode = 1'b0;
        adr = 5'h00; dat = 32'h0000_0000;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        wb(1'b0, OFF_PERIOD, 32'h0000_0000);
        chk(q, 32'h0000_00FF);
        wb(1'b0, 5'h14, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        tSwOneShot();
        for (int m = 3; m <= 5; m++) tEdgeLimit(5'(m));
        tLevelLimit(5'h06);
        tLevelLimit(5'h07);
        tMono();
        tReserved();
        tSleep();
        tOneShots();
        summarize();
    end
endmodule // hlt_timer_test
